// file: daa_regs_pkg.sv
// Constants and carriers for the line interface control and status registers
package daa_regs_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] powerdown_control_addr = 8'h06;
  localparam logic [7:0] sample_rate_control_addr = 8'h07;
  localparam logic [7:0] reserved_a_addr = 8'h08;
  localparam logic [7:0] reserved_b_addr = 8'h09;
  localparam logic [7:0] loopback_control_addr = 8'h0a;
  localparam logic [7:0] device_identification_addr = 8'h0b;
  localparam logic [7:0] line_side_status_addr = 8'h0c;
  localparam logic [7:0] line_side_revision_addr = 8'h0d;
  localparam logic [7:0] ring_output_polarity_addr = 8'h0e;
  localparam logic [7:0] slot_count = 8'h09;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int line_side_powerdown_bit = 4;
  localparam int system_side_powerdown_bit = 3;
  localparam int high_speed_sampling_bit = 3;
  localparam int data_loopback_enable_bit = 0;
  localparam int ring_output_polarity_sel_bit = 1;
  localparam int frame_lock_status_bit = 6;
  localparam int loop_current_msb = 4;
  localparam int variant_lsb = 4;
  localparam int line_rev_lsb = 2;
  localparam int line_rev_one_bit = 6;

  // ----------------------------------------
  // Reset values and loop current codes
  // ----------------------------------------
  localparam logic [7:0] powerdown_control_reset = 8'h10;
  localparam logic [7:0] plain_reset = 8'h00;
  localparam logic [4:0] loop_current_none = 5'h00;
  localparam logic [4:0] loop_current_min_normal = 5'h04;
  localparam logic [4:0] loop_current_overload = 5'h1f;

  // ----------------------------------------
  // Timing: highway frame 8 kHz, sample 8 kHz or 16 kHz
  // ----------------------------------------
  localparam int clk_rate_khz = 125000;
  localparam int frame_rate_khz = 8;
  localparam int frame_cycles = clk_rate_khz / frame_rate_khz;
  localparam int half_frame_cycles = frame_cycles / 2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic line_side_powerdown;
    logic system_side_powerdown;
    logic high_speed_sampling;
    logic data_loopback_enable;
    logic ring_output_polarity_sel;
  } ctrl_t;

endpackage : daa_regs_pkg

// file: daa_reg_store.sv
// Small register store for the writable control bytes
`timescale 1ns/1ps
`default_nettype none
module daa_reg_store #(
  parameter int depth = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] wr_mask,
  // Read port
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data
);

  initial
  begin
    if (depth < 1 || depth > 16)
    begin
      $error("depth out of range");
    end
  end

  logic [7:0] mem [depth];

  // ----------------------------------------
  // Storage with per-slot reset values
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < depth; g++)
    begin : g_slot
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          mem[g] <= (g == 0) ? daa_regs_pkg::powerdown_control_reset : daa_regs_pkg::plain_reset;
        end
        else if (wr_en && wr_idx == 4'(g))
        begin
          mem[g] <= wr_data & wr_mask;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
    end
    else if (int'(rd_idx) < depth)
    begin
      rd_data <= mem[rd_idx];
    end
    else
    begin
      rd_data <= 8'h00;
    end
  end

endmodule : daa_reg_store
`default_nettype wire

// file: daa_control_status_regs.sv
// Control and status register group of the system-side line interface device
// Functional notes
// RL1 - Line-side powerdown bit set holds line-side device in low power.
// RL2 - Host programs clock generator before clearing line-side powerdown.
// RL3 - System-side powerdown bit powers down until reset pin pulse.
// RL4 - High-speed sampling bit picks 8 kHz or 16 kHz sample rate.
// RL5 - At 16 kHz, frame stays 8 kHz, two samples in adjacent timeslots.
// RL6 - Loopback bit returns receive data unchanged on transmit data.
// RL7 - Revision bits 7:4 are fixed read-only line-side variant code.
// RL8 - Revision bits 3:0 are read-only system-side revision.
// RL9 - Status bit 6 reads isolation link frame lock.
// RL10 - Status bits 4:0 give loop current, all ones means overload.
// RL11 - Zero means too little current, 00100 marks the normal minimum.
// RL12 - Line-side revision: bits 5:2 revision, bit 6 one, rest zero.
// RL13 - Polarity bit makes ring detect output active low or high.
// RL14 - Host clears dropout interrupt flag after line-side power up.
// RL15 - Reserved bits and addresses read zero; writes ignored.
`timescale 1ns/1ps
`default_nettype none
module daa_control_status_regs #(
  parameter logic [3:0] line_side_variant_code = 4'ha, // Arbitrary value
  parameter logic [3:0] system_side_revision = 4'h5, // Arbitrary value
  parameter logic [3:0] line_side_revision_field = 4'h6, // Arbitrary value
  parameter int frame_cycles = daa_regs_pkg::frame_cycles
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control port
  input wire daa_regs_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Line-side status
  input wire logic frame_lock,
  input wire logic [4:0] loop_current_level,
  input wire logic ring_detected,
  // Serial data path
  input wire logic serial_receive_data,
  input wire logic filter_transmit_data,
  output logic serial_transmit_data,
  output logic filter_receive_data,
  // Converter timing, power, ring detect and loop current outputs
  output logic line_side_low_power,
  output logic system_side_powered_down,
  output logic sample_strobe,
  output logic second_slot,
  output logic frame_strobe,
  output logic ring_detect_output,
  output logic loop_current_overload,
  output logic loop_current_low
);

  initial
  begin
    if (frame_cycles < 4)
    begin
      $error("frame_cycles too small");
    end
  end

  typedef enum logic [1:0] {
    run_st = 2'b01,
    down_st = 2'b10
  } power_state_t;

  power_state_t power_state;
  daa_regs_pkg::ctrl_t ctrl;
  logic [7:0] store_rdata;
  logic [7:0] live_rdata;
  logic [7:0] rdata_hold;
  logic [7:0] wr_mask;
  logic wr_ok;
  logic rd_live;
  logic rd_pending;
  logic [31:0] frame_cnt;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [7:0] writable_mask(input logic [7:0] a);
    case (a)
      daa_regs_pkg::powerdown_control_addr: writable_mask = 8'h18;
      daa_regs_pkg::sample_rate_control_addr: writable_mask = 8'h08;
      daa_regs_pkg::loopback_control_addr: writable_mask = 8'h01;
      daa_regs_pkg::ring_output_polarity_addr: writable_mask = 8'h02;
      default: writable_mask = 8'h00;
    endcase
  endfunction : writable_mask

  function automatic logic [3:0] slot_of(input logic [7:0] a);
    slot_of = 4'(a - daa_regs_pkg::powerdown_control_addr);
  endfunction : slot_of

  assign wr_mask = writable_mask(req.addr);
  assign wr_ok = req.wr && (wr_mask != 8'h00) && (power_state == run_st); // RL15

  // ----------------------------------------
  // Writable bytes
  // ----------------------------------------
  daa_reg_store #(
    .depth(daa_regs_pkg::slot_count)
  ) u_store (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_ok),
    .wr_idx(slot_of(req.addr)),
    .wr_data(req.wdata),
    .wr_mask(wr_mask),
    .rd_idx(slot_of(req.addr)),
    .rd_data(store_rdata)
  );

  // Shadow control bits
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= '0;
      ctrl.line_side_powerdown <= daa_regs_pkg::powerdown_control_reset[daa_regs_pkg::line_side_powerdown_bit];
    end
    else if (wr_ok)
    begin
      case (req.addr)
        daa_regs_pkg::powerdown_control_addr:
        begin
          ctrl.line_side_powerdown <= req.wdata[daa_regs_pkg::line_side_powerdown_bit]; // RL1
          ctrl.system_side_powerdown <= req.wdata[daa_regs_pkg::system_side_powerdown_bit]; // RL3
        end
        daa_regs_pkg::sample_rate_control_addr:
          ctrl.high_speed_sampling <= req.wdata[daa_regs_pkg::high_speed_sampling_bit]; // RL4
        daa_regs_pkg::loopback_control_addr:
          ctrl.data_loopback_enable <= req.wdata[daa_regs_pkg::data_loopback_enable_bit]; // RL6
        daa_regs_pkg::ring_output_polarity_addr:
          ctrl.ring_output_polarity_sel <= req.wdata[daa_regs_pkg::ring_output_polarity_sel_bit]; // RL13
        default:
          ctrl <= ctrl;
      endcase
    end
  end

  // ----------------------------------------
  // System-side power state
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      power_state <= run_st;
    end
    else
    begin
      case (power_state)
        run_st:
          if (wr_ok && req.addr == daa_regs_pkg::powerdown_control_addr
              && req.wdata[daa_regs_pkg::system_side_powerdown_bit])
          begin
            power_state <= down_st; // RL3
          end
        down_st:
          power_state <= down_st; // RL3
        default:
          power_state <= run_st;
      endcase
    end
  end

  // ----------------------------------------
  // Read-only values
  // ----------------------------------------
  always_comb
  begin
    live_rdata = 8'h00; // RL15
    case (req.addr)
      daa_regs_pkg::device_identification_addr:
        live_rdata = {line_side_variant_code, system_side_revision}; // RL7 RL8
      daa_regs_pkg::line_side_status_addr:
      begin
        live_rdata[daa_regs_pkg::frame_lock_status_bit] = frame_lock; // RL9
        live_rdata[daa_regs_pkg::loop_current_msb:0] = loop_current_level; // RL10
      end
      daa_regs_pkg::line_side_revision_addr:
      begin
        live_rdata[daa_regs_pkg::line_rev_one_bit] = 1'b1; // RL12
        live_rdata[daa_regs_pkg::line_rev_lsb +: 4] = line_side_revision_field; // RL12
      end
      default:
        live_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_pending <= 1'b0;
      rd_live <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      rd_pending <= req.rd && power_state == run_st;
      rd_live <= (writable_mask(req.addr) == 8'h00);
      rvalid <= rd_pending;
      if (rd_pending)
      begin
        rdata <= rd_live ? rdata_hold : store_rdata; // RL15
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_hold <= 8'h00;
    end
    else
    begin
      rdata_hold <= live_rdata;
    end
  end

  // ----------------------------------------
  // Loop current classification
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loop_current_overload <= 1'b0;
      loop_current_low <= 1'b1;
    end
    else
    begin
      loop_current_overload <= loop_current_level == daa_regs_pkg::loop_current_overload; // RL10
      loop_current_low <= loop_current_level < daa_regs_pkg::loop_current_min_normal; // RL11
    end
  end

  // ----------------------------------------
  // Frame and sample timing
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || power_state != run_st)
    begin
      frame_cnt <= 32'h0;
      frame_strobe <= 1'b0;
      sample_strobe <= 1'b0;
      second_slot <= 1'b0;
    end
    else
    begin
      frame_cnt <= (frame_cnt == 32'(frame_cycles - 1)) ? 32'h0 : frame_cnt + 32'h1; // RL5
      frame_strobe <= frame_cnt == 32'h0; // RL5
      sample_strobe <= frame_cnt == 32'h0
        || (ctrl.high_speed_sampling && frame_cnt == 32'(frame_cycles / 2)); // RL4
      if (frame_cnt == 32'h0)
      begin
        second_slot <= 1'b0;
      end
      else if (ctrl.high_speed_sampling && frame_cnt == 32'(frame_cycles / 2))
      begin
        second_slot <= 1'b1; // RL5
      end
    end
  end

  // ----------------------------------------
  // Data path, power and ring outputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_transmit_data <= 1'b0;
      filter_receive_data <= 1'b0;
    end
    else
    begin
      serial_transmit_data <= ctrl.data_loopback_enable ? serial_receive_data : filter_transmit_data; // RL6
      filter_receive_data <= ctrl.data_loopback_enable ? 1'b0 : serial_receive_data; // RL6
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_side_low_power <= 1'b1;
      system_side_powered_down <= 1'b0;
      ring_detect_output <= 1'b1;
    end
    else
    begin
      line_side_low_power <= ctrl.line_side_powerdown; // RL1
      system_side_powered_down <= power_state == down_st; // RL3
      ring_detect_output <= ctrl.ring_output_polarity_sel ? ring_detected : ~ring_detected; // RL13
    end
  end

endmodule : daa_control_status_regs
`default_nettype wire

// file: daa_regs_asserts.sv
// Checker for the line interface register group
`timescale 1ns/1ps
`default_nettype none
module daa_regs_asserts #(
  parameter int frame_cycles = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control port
  input wire daa_regs_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Line side and serial path
  input wire logic frame_lock,
  input wire logic [4:0] loop_current_level,
  input wire logic ring_detected,
  input wire logic serial_receive_data,
  input wire logic filter_transmit_data,
  input wire logic serial_transmit_data,
  input wire logic filter_receive_data,
  // Controls
  input wire logic line_side_low_power,
  input wire logic system_side_powered_down,
  input wire logic sample_strobe,
  input wire logic second_slot,
  input wire logic frame_strobe,
  input wire logic ring_detect_output,
  input wire logic loop_current_overload,
  input wire logic loop_current_low
);
  logic lb_q;
  logic pol_q;
  logic seen;
  logic down_q;
  int gap;
  wire logic take_wr = req.wr && !down_q;

  // System-side powerdown as accepted on the bus
  always_ff @(posedge clk)
  begin
    if (rst)
      down_q <= 1'b0;
    else if (take_wr && req.addr == daa_regs_pkg::powerdown_control_addr && req.wdata[3])
      down_q <= 1'b1;
  end

  // Shadow control bits
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lb_q <= 1'b0;
      pol_q <= 1'b0;
    end
    else if (take_wr && req.addr == daa_regs_pkg::loopback_control_addr)
      lb_q <= req.wdata[0];
    else if (take_wr && req.addr == daa_regs_pkg::ring_output_polarity_addr)
      pol_q <= req.wdata[1];
  end

  // Cycles since last frame
  always_ff @(posedge clk)
  begin
    if (rst || frame_strobe)
      gap <= 0;
    else
      gap <= gap + 1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      seen <= 1'b0;
    else if (frame_strobe)
      seen <= 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rd_take_s;
    req.rd && !req.wr && !down_q;
  endsequence

  sequence pd_wr_s;
    take_wr && req.addr == daa_regs_pkg::powerdown_control_addr;
  endsequence

  read_answer_a: assert property (rd_take_s |-> ##2 rvalid)
    else $error("read not answered");
  read_blocked_a: assert property (req.rd && down_q |-> ##2 !rvalid)
    else $error("read answered while powered down");
  line_rev_a: assert property (rd_take_s ##0 req.addr == daa_regs_pkg::line_side_revision_addr
    |-> ##2 rdata[7:6] == 2'b01 && rdata[1:0] == 2'b00) else $error("line revision fixed bits wrong");
  line_power_a: assert property (pd_wr_s |-> ##2 line_side_low_power == $past(req.wdata[4], 2))
    else $error("line powerdown not applied");
  sys_down_a: assert property (pd_wr_s ##0 req.wdata[3] |-> ##2 system_side_powered_down)
    else $error("system powerdown not applied");
  sys_sticky_a: assert property (system_side_powered_down |=> system_side_powered_down)
    else $error("system powerdown left without reset");
  loop_path_a: assert property (lb_q |=> serial_transmit_data == $past(serial_receive_data))
    else $error("loopback data differs");
  ring_pol_a: assert property (1'b1 |=> ring_detect_output == ($past(ring_detected) ~^ $past(pol_q)))
    else $error("ring output polarity wrong");
  overload_flag_a: assert property (1'b1 |=> loop_current_overload == ($past(loop_current_level) == 5'h1f))
    else $error("overload flag wrong");
  low_current_a: assert property (1'b1 |=> loop_current_low == ($past(loop_current_level) < 5'h04))
    else $error("low current flag wrong");
  frame_period_a: assert property (frame_strobe && seen |-> gap == frame_cycles - 1)
    else $error("frame period wrong");
endmodule : daa_regs_asserts

bind daa_control_status_regs daa_regs_asserts #(.frame_cycles(frame_cycles)) chk (
  .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .frame_lock(frame_lock),
  .loop_current_level(loop_current_level), .ring_detected(ring_detected),
  .serial_receive_data(serial_receive_data), .filter_transmit_data(filter_transmit_data),
  .serial_transmit_data(serial_transmit_data), .filter_receive_data(filter_receive_data),
  .line_side_low_power(line_side_low_power), .system_side_powered_down(system_side_powered_down),
  .sample_strobe(sample_strobe), .second_slot(second_slot), .frame_strobe(frame_strobe),
  .ring_detect_output(ring_detect_output), .loop_current_overload(loop_current_overload),
  .loop_current_low(loop_current_low)
);
`default_nettype wire

// file: control_port_host.sv
// Host model driving the register control port
`timescale 1ns/1ps
`default_nettype none
module control_port_host #(
  parameter logic [7:0] dropout_flag_addr = 8'h04
) (
  // Clock
  input wire logic clk,
  // Control port
  output var daa_regs_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  logic clock_ready;

  initial
  begin
    req = '0;
    clock_ready = 1'b0;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic got);
    got = 1'b0;
    d = 8'h00;
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, ~a};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, a};
    for (int i = 0; i < 4 && !got; i++)
    begin
      @(posedge clk);
      got = (rvalid === 1'b1);
      d = rdata;
    end
  endtask : read_reg

  // Line side back to normal operation
  task automatic power_up_line();
    clock_ready = 1'b1;
    write_reg(daa_regs_pkg::powerdown_control_addr, 8'h00);
    write_reg(dropout_flag_addr, 8'h00);
  endtask : power_up_line
endmodule : control_port_host
`default_nettype wire

// file: daa_control_status_regs_tb_top.sv
// Testbench for the line interface register group
`timescale 1ns/1ps
`default_nettype none
module daa_control_status_regs_tb_top;
  localparam int fc = 16;
  localparam logic [3:0] var_code = 4'h9; // arbitrary
  localparam logic [3:0] sys_rev = 4'h2; // arbitrary
  localparam logic [3:0] line_rev = 4'hc; // arbitrary
  logic clk, rst, rvalid, lock, ring, rx, ftx, tx, frx, lowp, pd, smp, slot2, frm, rout, ovl, lowc, got;
  logic [4:0] lcl;
  logic [7:0] rdata, rb, a, d, cs, cf, c2;
  logic [7:0] shadow [16];
  daa_regs_pkg::reg_req_t req;
  int err_total, checks, seed, n;

  daa_control_status_regs #(.line_side_variant_code(var_code), .system_side_revision(sys_rev),
    .line_side_revision_field(line_rev), .frame_cycles(fc)) uut (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .frame_lock(lock),
    .loop_current_level(lcl), .ring_detected(ring), .serial_receive_data(rx),
    .filter_transmit_data(ftx), .serial_transmit_data(tx), .filter_receive_data(frx),
    .line_side_low_power(lowp), .system_side_powered_down(pd), .sample_strobe(smp),
    .second_slot(slot2), .frame_strobe(frm), .ring_detect_output(rout),
    .loop_current_overload(ovl), .loop_current_low(lowc));
  control_port_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  function automatic logic [7:0] msk(input logic [7:0] x);
    case (x)
      8'h06: msk = 8'h18;
      8'h07: msk = 8'h08;
      8'h0a: msk = 8'h01;
      8'h0e: msk = 8'h02;
      default: msk = 8'h00;
    endcase
  endfunction : msk

  function automatic logic [7:0] exp_reg(input logic [7:0] x);
    case (x)
      8'h0b: exp_reg = {var_code, sys_rev};
      8'h0c: exp_reg = {1'b0, lock, 1'b0, lcl};
      8'h0d: exp_reg = {2'b01, line_rev, 2'b00};
      default: exp_reg = (x < 8'h10) ? shadow[x[3:0]] : 8'h00;
    endcase
  endfunction : exp_reg

  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_pin(input string nm, input logic e, input logic g);
    cmp_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : cmp_pin

  task automatic wr(input logic [7:0] x, input logic [7:0] v);
    host.write_reg(x, v);
    if (x < 8'h10)
      shadow[x[3:0]] = (shadow[x[3:0]] & ~msk(x)) | (v & msk(x));
  endtask : wr

  task automatic rd_chk(input logic [7:0] x);
    host.read_reg(x, rb, got);
    cmp_pin("answer", 1'b1, got);
    cmp_byte("register", exp_reg(x), rb);
  endtask : rd_chk

  task automatic shadow_reset();
    foreach (shadow[i])
      shadow[i] = 8'h00;
    shadow[6] = 8'h10;
  endtask : shadow_reset

  task automatic rand_inputs(input int k);
    logic [4:0] corner [5] = '{5'h00, 5'h03, 5'h04, 5'h1e, 5'h1f};
    logic [8:0] v;
    v = 9'($random(seed));
    if (k < 5)
      v[4:0] = corner[k];
    @(posedge clk);
    {lock, ring, rx, ftx, lcl} <= v;
  endtask : rand_inputs

  task automatic check_pins();
    repeat (2) @(posedge clk);
    #1;
    cmp_pin("low_power", shadow[6][4], lowp);
    cmp_pin("ring_out", shadow[14][1] ? ring : !ring, rout);
    cmp_pin("tx", shadow[10][0] ? rx : ftx, tx);
    cmp_pin("filter_rx", shadow[10][0] ? 1'b0 : rx, frx);
    cmp_pin("overload", lcl == 5'h1f, ovl);
    cmp_pin("low_current", lcl < 5'h04, lowc);
  endtask : check_pins

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #(8 * 20000);
    err_total++;
    finish_test();
  end

  initial
  begin
    {rst, lock, ring, rx, ftx, lcl} = {1'b1, 9'h000};
    seed = 32'hc540;
    err_total = 0;
    checks = 0;
    shadow_reset();
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (n = 6; n < 16; n++)
      rd_chk(8'(n));
    rd_chk(8'h40);
    $display("test reset_values done");
    for (n = 0; n < 40; n++)
    begin
      rand_inputs(n);
      a = 8'h06 + 8'(unsigned'($random(seed)) % 10);
      d = 8'($random(seed));
      if (a == 8'h06)
        d[3] = 1'b0;
      wr(a, d);
      check_pins();
      rd_chk(a);
      rd_chk(8'h0c);
    end
    $display("test random_access done");
    for (n = 0; n < 2; n++)
    begin
      wr(daa_regs_pkg::sample_rate_control_addr, n ? 8'h08 : 8'h00);
      repeat (2 * fc) @(posedge clk);
      cs = 8'h00;
      cf = 8'h00;
      c2 = 8'h00;
      repeat (4 * fc)
      begin
        @(posedge clk);
        cs = cs + {7'h00, smp};
        cf = cf + {7'h00, frm};
        c2 = c2 + {7'h00, slot2};
      end
      cmp_byte("second_slot", n ? 8'(2 * fc) : 8'h00, c2);
      cmp_byte("frames", 8'h04, cf);
      cmp_byte("samples", n ? 8'h08 : 8'h04, cs);
    end
    $display("test sample_rate done");
    wr(daa_regs_pkg::powerdown_control_addr, 8'h10);
    check_pins();
    host.power_up_line();
    shadow[6] = 8'h00;
    check_pins();
    host.write_reg(daa_regs_pkg::powerdown_control_addr, 8'h08);
    @(posedge clk);
    #1;
    cmp_pin("powered_down", 1'b1, pd);
    host.write_reg(daa_regs_pkg::ring_output_polarity_addr, 8'h02);
    host.read_reg(daa_regs_pkg::powerdown_control_addr, rb, got);
    cmp_pin("answer", 1'b0, got);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    shadow_reset();
    @(posedge clk);
    #1;
    cmp_pin("powered_down", 1'b0, pd);
    rd_chk(daa_regs_pkg::ring_output_polarity_addr);
    $display("test powerdown done");
    finish_test();
  end
endmodule : daa_control_status_regs_tb_top
`default_nettype wire
